// ===== design/rco_top.sv
// Relay output conditioner: relay A (standard) and relay B (latching)
// with delays, speed and load comparators, clear code and wake timer.
// Assumes freq_pm, load_pm and src_ext come from logic on pclk;
// mains_ok and reset_contact_n are pins. The block sits on a
// battery-backed rail so the wake timer runs after mains loss.
`timescale 1ns/1ps
module rco_top #(
    parameter int unsigned SEC_CYC = rco_pkg::TICK_CYC,
    parameter int DW = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive state, same clock; freq_pm and load_pm in tenths of a percent
    input wire logic [DW-1:0] freq_pm,
    input wire logic [DW-1:0] load_pm,
    input wire logic [1:0] src_ext,
    // Pins
    input wire logic mains_ok,
    input wire logic reset_contact_n,
    // Relays and interrupt
    output logic relay_a,
    output logic relay_b,
    output logic relay_wake,
    output logic irq
);
    localparam int PW = $clog2(SEC_CYC + 1);

    typedef struct packed {
        logic [6:0] ctrl;
        logic [DW-1:0] ton_a, toff_a, ton_b, toff_b;
        logic [DW-1:0] thr_un, thr_ov;
        logic [4:0] wk_h;
        logic [5:0] wk_m, wk_s;
        logic [DW-1:0] cal_lf, cal_ll, cal_hf, cal_hl;
        logic [1:0] cal_v;
        logic [1:0] code_idx;
        logic latch, rly_a, rly_b, under, over, lwarn;
        logic mains_m, mains_s, mains_p, cont_m, cont_s;
        logic [15:0] wk_cnt;
        logic wk_run, wk_rly;
        logic [PW-1:0] pre;
        logic tick;
        logic [3:0] irq_st, irq_mk;
        logic irq;
        logic pready, pslverr;
        logic [31:0] prdata;
    } rco_st_t;

    rco_st_t q;
    rco_st_t d;

    rco_dly_if #(.W(DW)) a_if ();
    rco_dly_if #(.W(DW)) b_if ();

    // ------------------------------------------------------------
    // Delay stages
    // ------------------------------------------------------------
    rco_delay #(.W(DW)) u_dly_a (
        .pclk(pclk),
        .presetn(presetn),
        .dl(a_if.tmr)
    );
    rco_delay #(.W(DW)) u_dly_b (
        .pclk(pclk),
        .presetn(presetn),
        .dl(b_if.tmr)
    );

    // Source order: external, under-speed, over-speed, load warning
    logic [3:0] srcs_a;
    logic [3:0] srcs_b;
    assign srcs_a = {q.lwarn, q.over, q.under, src_ext[0]};
    assign srcs_b = {q.lwarn, q.over, q.under, src_ext[1]};
    assign a_if.src = srcs_a[q.ctrl[rco_pkg::CT_SEL_A +: 2]];
    assign b_if.src = srcs_b[q.ctrl[rco_pkg::CT_SEL_B +: 2]];
    assign a_if.on_dly = q.ton_a;
    assign a_if.off_dly = q.toff_a;
    assign b_if.on_dly = q.ton_b;
    assign b_if.off_dly = q.toff_b;
    assign a_if.tick = q.tick;
    assign b_if.tick = q.tick;

    // ------------------------------------------------------------
    // Load line and derived terms
    // ------------------------------------------------------------
    logic signed [DW:0] df, dl, fx, lx;
    logic signed [2*DW+1:0] lhs, rhs;
    logic lw_c;
    logic [21:0] wk_tgt;
    logic [15:0] wk_lim;
    logic setup, wr, hit, lmode, code_wr, code_ok;
    logic [3:0] code_exp, ev, clr;
    logic [31:0] rd;

    // Compare by cross multiplication; no divider needed
    assign df = $signed({1'b0, q.cal_hf}) - $signed({1'b0, q.cal_lf});
    assign dl = $signed({1'b0, q.cal_hl}) - $signed({1'b0, q.cal_ll});
    assign fx = $signed({1'b0, freq_pm}) - $signed({1'b0, q.cal_lf});
    assign lx = $signed({1'b0, load_pm}) - $signed({1'b0, q.cal_ll});
    assign lhs = (2*DW+2)'(lx) * (2*DW+2)'(df);
    assign rhs = (2*DW+2)'(dl) * (2*DW+2)'(fx);
    // A line with zero or reversed speed span is treated as uncalibrated
    assign lw_c = (&q.cal_v) && (df > 0) && (lhs > rhs);

    assign wk_tgt = 22'(q.wk_h) * 22'(rco_pkg::HOUR_S)
        + 22'(q.wk_m) * 22'(rco_pkg::MIN_S) + 22'(q.wk_s);
    assign wk_lim = (wk_tgt > 22'(rco_pkg::WAKE_MAX)) ? rco_pkg::WAKE_MAX
        : wk_tgt[15:0];

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && q.pready;
    assign lmode = q.ctrl[rco_pkg::CT_LMODE];
    assign code_wr = wr && (paddr == rco_pkg::A_CODE) && lmode;
    assign code_exp = rco_pkg::CLR_CODE[{~q.code_idx, 2'b00} +: 4];
    assign code_ok = code_wr && (q.code_idx == 2'h3)
        && (pwdata[3:0] == code_exp);
    assign clr = (wr && paddr == rco_pkg::A_IRQS) ? pwdata[3:0] : 4'h0;

    function automatic logic [DW-1:0] clamp(input logic [DW-1:0] v,
                                            input logic [DW-1:0] mx);
        clamp = (v > mx) ? mx : v;
    endfunction : clamp

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            rco_pkg::A_CTRL: rd[6:0] = q.ctrl;
            rco_pkg::A_DLY_A: rd = {6'h00, q.toff_a, 6'h00, q.ton_a};
            rco_pkg::A_DLY_B: rd = {6'h00, q.toff_b, 6'h00, q.ton_b};
            rco_pkg::A_SPD: rd = {6'h00, q.thr_ov, 6'h00, q.thr_un};
            rco_pkg::A_CAL: rd[1:0] = q.cal_v;
            rco_pkg::A_CODE: rd[1:0] = q.code_idx;
            rco_pkg::A_WAKE: rd = {11'h000, q.wk_h, 2'h0, q.wk_m, 2'h0, q.wk_s};
            rco_pkg::A_STAT: rd = {q.wk_cnt, 4'h0, q.code_idx, q.cal_v, q.wk_run,
                q.wk_rly, q.lwarn, q.over, q.under, q.latch, q.rly_b, q.rly_a};
            rco_pkg::A_IRQS: rd[3:0] = q.irq_st;
            rco_pkg::A_IRQM: rd[3:0] = q.irq_mk;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // Pin synchronisers
        d.mains_m = mains_ok;
        d.mains_s = q.mains_m;
        d.mains_p = q.mains_s;
        d.cont_m = reset_contact_n;
        d.cont_s = q.cont_m;
        // One-second tick
        d.tick = 1'b0;
        if (q.pre >= PW'(SEC_CYC - 1)) begin
            d.pre = '0;
            d.tick = 1'b1;
        end else begin
            d.pre = q.pre + 1'b1;
        end
        // Comparators
        d.under = freq_pm < q.thr_un;
        d.over = freq_pm > q.thr_ov;
        d.lwarn = lw_c;
        // Relay A
        d.rly_a = a_if.act ^ q.ctrl[rco_pkg::CT_INV_A];
        // Relay B: contact only counts in latched mode
        if (!lmode) begin
            d.latch = b_if.act;
        end else if (b_if.act) begin
            d.latch = 1'b1;
        end else if (code_ok || !q.cont_s) begin
            d.latch = 1'b0;
        end
        d.rly_b = q.latch ^ q.ctrl[rco_pkg::CT_INV_B];
        // Clear code entry; leaving latched mode drops it
        if (!lmode) begin
            d.code_idx = 2'h0;
        end else if (code_wr) begin
            if (pwdata[3:0] == code_exp) begin
                d.code_idx = q.code_idx + 2'h1;
            end else begin
                d.code_idx = 2'h0;
            end
        end
        // Wake timer; first second may be partial
        if (q.mains_s) begin
            d.wk_run = 1'b0;
            d.wk_rly = 1'b0;
        end else if (q.mains_p) begin
            d.wk_cnt = wk_lim;
            d.wk_run = (wk_lim != 16'h0000);
            d.wk_rly = (wk_lim == 16'h0000);
        end else if (q.wk_run && q.tick) begin
            d.wk_cnt = q.wk_cnt - 16'h0001;
            if (q.wk_cnt == 16'h0001) begin
                d.wk_run = 1'b0;
                d.wk_rly = 1'b1;
            end
        end
        // Register writes
        if (wr) begin
            case (paddr)
                rco_pkg::A_CTRL: d.ctrl = pwdata[6:0];
                rco_pkg::A_DLY_A: begin
                    d.ton_a = clamp(pwdata[DW-1:0], rco_pkg::DLY_MAX);
                    d.toff_a = clamp(pwdata[rco_pkg::F_HI +: DW], rco_pkg::DLY_MAX);
                end
                rco_pkg::A_DLY_B: begin
                    d.ton_b = clamp(pwdata[DW-1:0], rco_pkg::DLY_MAX);
                    d.toff_b = clamp(pwdata[rco_pkg::F_HI +: DW], rco_pkg::DLY_MAX);
                end
                rco_pkg::A_SPD: begin
                    d.thr_un = clamp(pwdata[DW-1:0], rco_pkg::PCT_FULL);
                    d.thr_ov = clamp(pwdata[rco_pkg::F_HI +: DW], rco_pkg::PCT_FULL);
                end
                rco_pkg::A_CAL: begin
                    if (pwdata[0]) begin
                        d.cal_lf = freq_pm;
                        d.cal_ll = load_pm;
                        d.cal_v[0] = 1'b1;
                    end
                    if (pwdata[1]) begin
                        d.cal_hf = freq_pm;
                        d.cal_hl = load_pm;
                        d.cal_v[1] = 1'b1;
                    end
                end
                rco_pkg::A_WAKE: begin
                    d.wk_h = pwdata[rco_pkg::WK_H +: 5];
                    d.wk_m = pwdata[rco_pkg::WK_M +: 6];
                    d.wk_s = pwdata[rco_pkg::WK_S +: 6];
                end
                rco_pkg::A_IRQM: d.irq_mk = pwdata[3:0];
                default: d.ctrl = q.ctrl;
            endcase
        end
        // Interrupts: a new event wins over a same-cycle clear
        ev = 4'h0;
        ev[rco_pkg::IRQ_RLA] = d.rly_a != q.rly_a;
        ev[rco_pkg::IRQ_LSET] = d.latch && !q.latch;
        ev[rco_pkg::IRQ_WAKE] = d.wk_rly && !q.wk_rly;
        ev[rco_pkg::IRQ_LWARN] = d.lwarn && !q.lwarn;
        d.irq_st = (q.irq_st & ~clr) | ev;
        d.irq = |(q.irq_st & q.irq_mk);
        // APB answer one cycle after setup
        d.pready = setup;
        d.pslverr = setup && !hit;
        d.prdata = setup ? rd : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ton_a <= rco_pkg::RST_TON;
            q.ton_b <= rco_pkg::RST_TON;
            q.toff_a <= rco_pkg::RST_TOFF;
            q.toff_b <= rco_pkg::RST_TOFF;
            q.thr_un <= rco_pkg::RST_UNDER;
            q.thr_ov <= rco_pkg::RST_OVER;
            q.mains_m <= 1'b1;
            q.mains_s <= 1'b1;
            q.mains_p <= 1'b1;
            q.cont_m <= 1'b1;
            q.cont_s <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign relay_a = q.rly_a;
    assign relay_b = q.rly_b;
    assign relay_wake = q.wk_rly;
    assign irq = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    relay_polarity_a: assert property (
        1'b1 |=> relay_a == ($past(a_if.act) ^ $past(q.ctrl[rco_pkg::CT_INV_A])))
        else $error("relay A polarity wrong");
    underspeed_cmp_a: assert property (
        freq_pm < q.thr_un |=> q.under)
        else $error("under-speed not flagged");
    overspeed_cmp_a: assert property (
        freq_pm <= q.thr_ov |=> !q.over)
        else $error("over-speed flagged at or below threshold");
    latch_holds_a: assert property (
        lmode && b_if.act |=> q.latch)
        else $error("latched relay released with source active");
    contact_release_a: assert property (
        lmode && !q.cont_s && !b_if.act |=> !q.latch)
        else $error("reset contact failed to release");
    standard_follow_a: assert property (
        !lmode |=> q.latch == $past(b_if.act))
        else $error("standard mode not following source");
    code_busy_src_a: assert property (
        code_ok && b_if.act |=> q.latch)
        else $error("code released relay with source active");
    code_discard_a: assert property (
        code_wr && pwdata[3:0] != code_exp |=> q.code_idx == 2'h0)
        else $error("wrong digit kept the entry");
    wake_start_a: assert property (
        q.mains_p && !q.mains_s && wk_lim != 16'h0000 |=> q.wk_run && q.wk_cnt == $past(wk_lim))
        else $error("wake timer not started at mains loss");
    wake_expire_a: assert property (
        q.wk_run && q.tick && q.wk_cnt == 16'h0001 && !q.mains_s |=> relay_wake)
        else $error("wake relay not operated at expiry");
endmodule : rco_top

// ===== design/rco_pkg.sv
// Shared constants for the relay output conditioner: register map,
// field positions, reset values and timing.
// Assumes one APB clock domain at 25 MHz.
package rco_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DLY_A = 8'h04;
    localparam logic [7:0] A_DLY_B = 8'h08;
    localparam logic [7:0] A_SPD = 8'h0C;
    localparam logic [7:0] A_CAL = 8'h10;
    localparam logic [7:0] A_CODE = 8'h14;
    localparam logic [7:0] A_WAKE = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1C;
    localparam logic [7:0] A_IRQS = 8'h20;
    localparam logic [7:0] A_IRQM = 8'h24;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CT_SEL_A = 0;
    localparam int CT_SEL_B = 2;
    localparam int CT_INV_A = 4;
    localparam int CT_INV_B = 5;
    localparam int CT_LMODE = 6;
    localparam int F_HI = 16;
    localparam int WK_H = 16;
    localparam int WK_M = 8;
    localparam int WK_S = 0;
    localparam int IRQ_RLA = 0;
    localparam int IRQ_LSET = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_LWARN = 3;
    // ------------------------------------------------------------
    // Values after reset and limits (percent in tenths)
    // ------------------------------------------------------------
    localparam logic [9:0] RST_UNDER = 10'h0C8;
    localparam logic [9:0] RST_OVER = 10'h320;
    localparam logic [9:0] RST_TON = 10'h000;
    localparam logic [9:0] RST_TOFF = 10'h000;
    localparam logic [9:0] PCT_FULL = 10'h3E8;
    localparam logic [9:0] DLY_MAX = 10'h258;
    localparam logic [15:0] CLR_CODE = 16'h1580;
    localparam logic [15:0] WAKE_MAX = 16'hFFFF;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned TICK_NS = 1000000000;
    localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned HOUR_S = 3600;
    localparam int unsigned MIN_S = 60;
endpackage : rco_pkg

// ===== design/rco_dly_if.sv
// Link between the conditioner core and one delay stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rco_dly_if #(parameter int W = 10);
    logic src;
    logic [W-1:0] on_dly;
    logic [W-1:0] off_dly;
    logic tick;
    logic act;
    modport ctl (output src, output on_dly, output off_dly, output tick, input act);
    modport tmr (input src, input on_dly, input off_dly, input tick, output act);
endinterface : rco_dly_if

// ===== design/rco_delay.sv
// One relay delay stage: activate and de-activate delays in seconds.
// Assumes a one-cycle tick each second on the same clock.
`timescale 1ns/1ps
module rco_delay #(
    parameter int W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    rco_dly_if.tmr dl
);
    typedef struct packed {
        logic act;
        logic [W-1:0] cnt;
    } rco_dly_st_t;

    rco_dly_st_t q;
    rco_dly_st_t d;
    logic [W-1:0] lim;

    // ------------------------------------------------------------
    // Delay count
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        lim = dl.src ? dl.on_dly : dl.off_dly;
        if (dl.src == q.act) begin
            d.cnt = '0;
        end else if (q.cnt >= lim) begin
            d.act = dl.src;
            d.cnt = '0;
        end else if (dl.tick) begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dl.act = q.act;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    off_delay_a: assert property (
        $fell(q.act) |-> $past(q.cnt) >= $past(dl.off_dly) && !$past(dl.src))
        else $error("relay dropped before its release delay");
    on_delay_a: assert property (
        $rose(q.act) |-> $past(q.cnt) >= $past(dl.on_dly) && $past(dl.src))
        else $error("relay energised before its activate delay");
    delay_restart_a: assert property (
        dl.src == q.act |=> q.cnt == '0)
        else $error("delay count not restarted");
endmodule : rco_delay

// ===== sim/rco_contacts.sv
// Behavioural model of the relay contacts and the switchgear behind them.
// Assumes the relay drives are registered levels on pclk.
`timescale 1ns/1ps
module rco_contacts (
    // Clock
    input wire logic pclk,
    // Relay coils
    input wire logic relay_a,
    input wire logic relay_b,
    input wire logic relay_wake,
    // Contact state: [0] relay A, [1] latching relay, [2] wake relay
    output logic [2:0] closed
);
    // Contacts settle one cycle after the coil; the switchgear only sees levels
    always_ff @(posedge pclk) begin
        closed <= {relay_wake, relay_b, relay_a};
    end
endmodule : rco_contacts

// ===== sim/relay_output_conditioner_bench.sv
// Self-checking bench for rco_top: APB master, drive state and pins.
// Assumes SEC_CYC is shortened to 10 cycles per second.
`timescale 1ns/1ps
module relay_output_conditioner_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] freq_pm = 10'h000;
    logic [9:0] load_pm = 10'h000;
    logic [1:0] src_ext = 2'h0;
    logic mains_ok = 1'b1;
    logic reset_contact_n = 1'b1;
    logic relay_a;
    logic relay_b;
    logic relay_wake;
    logic irq;
    logic [2:0] closed;
    logic [31:0] q;
    logic e;
    int error_cnt = 0;
    int cmp_count = 0;
    always #20 pclk = ~pclk;
    rco_top #(.SEC_CYC(10), .DW(10)) dut_u (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .freq_pm(freq_pm), .load_pm(load_pm), .src_ext(src_ext),
        .mains_ok(mains_ok), .reset_contact_n(reset_contact_n),
        .relay_a(relay_a), .relay_b(relay_b), .relay_wake(relay_wake), .irq(irq));
    rco_contacts sw_u (.pclk(pclk), .relay_a(relay_a), .relay_b(relay_b),
        .relay_wake(relay_wake), .closed(closed));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Slave may stretch; only the watchdog ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic wait_rly(input int i, input logic v, input int n);
        int k;
        k = 0;
        while (closed[i] !== v && k < n) begin
            k++;
            @(posedge pclk);
        end
    endtask : wait_rly
    task automatic hold(input string nm, input int i, input logic v, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            bad = bad | (closed[i] !== v);
        end
        check(nm, bad, 1'b0);
    endtask : hold
    task automatic code(input logic [3:0] d);
        apb(1'b1, rco_pkg::A_CODE, {28'h0, d});
    endtask : code
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, rco_pkg::A_SPD, 32'h0);
        check("spd", q, {6'h00, rco_pkg::RST_OVER, 6'h00, rco_pkg::RST_UNDER});
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped rd", q, 32'h0);
        check("unmapped err", e, 1'b1);
        check("relays", {closed, irq}, 4'h0);
    endtask : t_reset
    task automatic t_invert();
        src_ext <= 2'h1;
        wait_rly(0, 1'b1, 8);
        check("rly_a on", closed[0], 1'b1);
        src_ext <= 2'h0;
        wait_rly(0, 1'b0, 8);
        check("rly_a off", closed[0], 1'b0);
        apb(1'b1, rco_pkg::A_CTRL, 32'h10);
        wait_rly(0, 1'b1, 8);
        check("rly_a inv", closed[0], 1'b1);
        apb(1'b1, rco_pkg::A_CTRL, 32'h0);
    endtask : t_invert
    task automatic t_speed();
        apb(1'b1, rco_pkg::A_CTRL, 32'h1);
        freq_pm <= 10'h064;
        wait_rly(0, 1'b1, 8);
        check("under 100", closed[0], 1'b1);
        freq_pm <= 10'h0C8;
        wait_rly(0, 1'b0, 8);
        check("under 200", closed[0], 1'b0);
        apb(1'b1, rco_pkg::A_CTRL, 32'h2);
        freq_pm <= 10'h321;
        wait_rly(0, 1'b1, 8);
        check("over 801", closed[0], 1'b1);
        freq_pm <= 10'h320;
        wait_rly(0, 1'b0, 8);
        check("over 800", closed[0], 1'b0);
    endtask : t_speed
    task automatic t_load();
        // Operator order: half speed first, then full speed
        freq_pm <= 10'h1F4;
        load_pm <= 10'h12C;
        apb(1'b1, rco_pkg::A_CAL, 32'h1);
        freq_pm <= 10'h3E8;
        load_pm <= 10'h258;
        apb(1'b1, rco_pkg::A_CAL, 32'h2);
        apb(1'b0, rco_pkg::A_CAL, 32'h0);
        check("cal flags", q[1:0], 2'h3);
        apb(1'b1, rco_pkg::A_CTRL, 32'h3);
        freq_pm <= 10'h2EE;
        load_pm <= 10'h1F4;
        wait_rly(0, 1'b1, 8);
        check("load above", closed[0], 1'b1);
        check("irq masked", irq, 1'b0);
        apb(1'b0, rco_pkg::A_IRQS, 32'h0);
        check("lwarn sticky", q[rco_pkg::IRQ_LWARN], 1'b1);
        apb(1'b1, rco_pkg::A_IRQM, 32'h8);
        cyc(2);
        check("irq on", irq, 1'b1);
        load_pm <= 10'h190;
        wait_rly(0, 1'b0, 8);
        check("load below", closed[0], 1'b0);
        apb(1'b1, rco_pkg::A_IRQS, 32'h8);
        cyc(3);
        check("irq clear", irq, 1'b0);
        apb(1'b1, rco_pkg::A_IRQM, 32'h0);
        apb(1'b1, rco_pkg::A_CTRL, 32'h0);
    endtask : t_load
    task automatic t_delay();
        apb(1'b1, rco_pkg::A_DLY_A, 32'h02BC_0000);
        apb(1'b0, rco_pkg::A_DLY_A, 32'h0);
        check("off clamp", q, {6'h00, rco_pkg::DLY_MAX, 16'h0000});
        apb(1'b1, rco_pkg::A_DLY_A, 32'h0003_0002);
        src_ext <= 2'h1;
        hold("on wait", 0, 1'b0, 8);
        wait_rly(0, 1'b1, 30);
        check("on done", closed[0], 1'b1);
        src_ext <= 2'h0;
        cyc(5);
        src_ext <= 2'h1;
        hold("off restart", 0, 1'b1, 40);
        src_ext <= 2'h0;
        hold("off wait", 0, 1'b1, 15);
        wait_rly(0, 1'b0, 30);
        check("off done", closed[0], 1'b0);
        apb(1'b1, rco_pkg::A_DLY_A, 32'h0);
    endtask : t_delay
    task automatic t_latch();
        logic [3:0] dg [4];
        dg = '{4'h1, 4'h5, 4'h8, 4'h0};
        apb(1'b1, rco_pkg::A_CTRL, 32'h40);
        src_ext <= 2'h2;
        wait_rly(1, 1'b1, 8);
        check("latch set", closed[1], 1'b1);
        src_ext <= 2'h0;
        hold("latched", 1, 1'b1, 10);
        code(4'h1);
        code(4'h5);
        apb(1'b0, rco_pkg::A_CODE, 32'h0);
        check("code idx", q[1:0], 2'h2);
        code(4'h9);
        apb(1'b0, rco_pkg::A_CODE, 32'h0);
        check("code drop", q[1:0], 2'h0);
        code(4'h8);
        code(4'h0);
        hold("bad code", 1, 1'b1, 5);
        for (int i = 0; i < 4; i++) code(dg[i]);
        wait_rly(1, 1'b0, 8);
        check("code clear", closed[1], 1'b0);
        src_ext <= 2'h2;
        for (int i = 0; i < 4; i++) code(dg[i]);
        hold("src busy", 1, 1'b1, 5);
        src_ext <= 2'h0;
        cyc(5);
        reset_contact_n <= 1'b0;
        wait_rly(1, 1'b0, 12);
        check("contact clr", closed[1], 1'b0);
        reset_contact_n <= 1'b1;
        apb(1'b1, rco_pkg::A_CTRL, 32'h0);
        // Digits outside latched mode must not advance the entry
        code(4'h1);
        apb(1'b0, rco_pkg::A_CODE, 32'h0);
        check("code ignored", q[1:0], 2'h0);
        apb(1'b1, rco_pkg::A_CTRL, 32'h20);
        wait_rly(1, 1'b1, 8);
        check("rly_b inv", closed[1], 1'b1);
        src_ext <= 2'h2;
        reset_contact_n <= 1'b0;
        wait_rly(1, 1'b0, 8);
        hold("contact ignored", 1, 1'b0, 8);
        reset_contact_n <= 1'b1;
        src_ext <= 2'h0;
        apb(1'b1, rco_pkg::A_CTRL, 32'h0);
    endtask : t_latch
    task automatic t_wake();
        apb(1'b1, rco_pkg::A_WAKE, 32'h0012_0C0F);
        apb(1'b0, rco_pkg::A_WAKE, 32'h0);
        check("wake max", q, 32'h0012_0C0F);
        apb(1'b1, rco_pkg::A_WAKE, 32'h3);
        mains_ok <= 1'b0;
        hold("wake run", 2, 1'b0, 12);
        wait_rly(2, 1'b1, 40);
        check("wake fire", closed[2], 1'b1);
        mains_ok <= 1'b1;
        wait_rly(2, 1'b0, 10);
        check("wake off", closed[2], 1'b0);
        apb(1'b1, rco_pkg::A_WAKE, 32'h0);
        mains_ok <= 1'b0;
        wait_rly(2, 1'b1, 10);
        check("wake zero", closed[2], 1'b1);
        mains_ok <= 1'b1;
    endtask : t_wake
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        // Whole run is well under 2000 cycles
        #(40 * 5000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_invert();
        t_speed();
        t_load();
        t_delay();
        t_latch();
        t_wake();
        print_verdict();
    end
endmodule : relay_output_conditioner_bench
